//--- rtl/hhp_regs.svh
/*
 mode and reset constants for the handler handshake polarity block.
 assumes it is included by bare name from rtl files.
*/
`ifndef HHP_REGS_SVH
`define HHP_REGS_SVH

// -----------------------------------------------------------------
// completion indicator modes
// -----------------------------------------------------------------
`define HHP_DONE_LOW 2'h0
`define HHP_DONE_HIGH 2'h1
`define HHP_DONE_INVLOW 2'h2
`define HHP_DONE_SPARE 2'h3
`define HHP_DONE_RST `HHP_DONE_HIGH

// -----------------------------------------------------------------
// busy polarity and trigger defaults
// -----------------------------------------------------------------
`define HHP_BUSY_HIGH 1'h1
`define HHP_BUSY_RST `HHP_BUSY_HIGH
`define HHP_EDGE_FIRST 1'h0
`define HHP_EDGE_SECOND 1'h1
`define HHP_EDGE_RST `HHP_EDGE_SECOND
`define HHP_ISO_RST 1'h1

`endif

//--- rtl/hhp_pkg.sv
/*
 types for the handler handshake polarity block.
 assumes nothing of its surroundings.
*/
package hhp_pkg;
	// measurement sequencer states
	typedef enum logic [1:0] {HHP_IDLE, HHP_MEAS, HHP_DONE} hhp_state_e;
endpackage : hhp_pkg

//--- rtl/hhp_top.sv
/*
 handshake between the instrument and a component handler: trigger
 qualification, busy and completion indicators with selectable polarity.
 assumes static configuration inputs and a measurement core that pulses
 meas_done_i; start_in_i is asynchronous.
*/
// Notes on behaviour
// R1: active-low mode drives completion low when done
// R2: active-high mode drives completion high when done
// R3: alternative mode holds completion low while invalid
// R4: busy high polarity holds busy high while invalid
// R5: busy low polarity holds busy low while invalid
// R6: trigger uses exactly one path, else ignored
// R7: first edge: isolated falling, logic rising
// R8: second edge: isolated rising, logic falling
// R9: reset default: high, high, isolated, rising
// R10: synchronise trigger, one start per edge
// R11: same behaviour in plain and sweep modes
`include "hhp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module hhp_top
	import hhp_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// configuration straps
	input wire logic [1:0] done_mode_i,
	input wire logic busy_pol_i,
	input wire logic path_logic_i,
	input wire logic path_iso_a_i,
	input wire logic path_iso_b_i,
	input wire logic edge_sel_i,
	input wire logic sweep_mode_i,
	// handler trigger pin
	input wire logic start_in_i,
	// measurement core
	input wire logic meas_done_i,
	output logic meas_start_o,
	// handler control outputs
	output logic done_o,
	output logic busy_o,
	output logic cfg_err_o
);

	// -----------------------------------------------------------------
	// synchroniser and configuration
	// -----------------------------------------------------------------
	logic sync1_r; // first stage, read only by sync2_r
	logic sync2_r; // second stage
	logic prev_r; // previous synchronised level
	logic [1:0] dmode_r; // latched completion mode
	logic bpol_r; // latched busy polarity
	logic esel_r; // latched edge option
	logic iso_r; // latched isolated path
	logic perr_r; // latched path conflict
	logic cfg_ld_r; // straps sampled once after release
	logic [1:0] arm_r; // edge detector armed once prev_r holds a real pin level

	// path legality: exactly one path chosen
	wire iso_ok = path_iso_a_i & path_iso_b_i & ~path_logic_i; // R6
	wire logic_ok = path_logic_i & ~path_iso_a_i & ~path_iso_b_i; // R6
	// sweep mode changes only bin meaning, never these controls
	wire unused_sweep = sweep_mode_i; // R11

	// sample straps on the first clock after reset, defaults meanwhile
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cfg_ld_r <= 1'h0;
			dmode_r <= `HHP_DONE_RST; // R9
			bpol_r <= `HHP_BUSY_RST; // R9
			esel_r <= `HHP_EDGE_RST; // R9
			iso_r <= `HHP_ISO_RST; // R9
			perr_r <= 1'h0;
		end
		else if (!cfg_ld_r)
		begin
			cfg_ld_r <= 1'h1;
			dmode_r <= done_mode_i;
			bpol_r <= busy_pol_i;
			esel_r <= edge_sel_i;
			iso_r <= iso_ok; // R6
			perr_r <= ~(iso_ok | logic_ok); // R6
		end
	end

	// two flip-flop synchroniser on the trigger pin
	// prev_r leaves reset low, so a pin idling high would look like a rising
	// edge; arm_r masks edge detection until the chain holds real pin levels
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_r <= 1'h0;
			sync2_r <= 1'h0;
			prev_r <= 1'h0;
			arm_r <= 2'h0;
		end
		else
		begin
			sync1_r <= start_in_i; // R10
			sync2_r <= sync1_r; // R10
			prev_r <= sync2_r;
			// shifts in the strap load flag, two edges behind it
			arm_r <= {arm_r[0], cfg_ld_r}; // R10
		end
	end

	// -----------------------------------------------------------------
	// edge qualification
	// -----------------------------------------------------------------
	wire rise = sync2_r & ~prev_r;
	wire fall = ~sync2_r & prev_r;
	// isolated path inverts the sense of each edge option
	wire want_rise = (esel_r == `HHP_EDGE_SECOND) ? iso_r : ~iso_r; // R7 R8
	// edges that fall inside the arming window after reset are dropped
	wire trig = arm_r[1] & ~perr_r & (want_rise ? rise : fall); // R7 R8 R10

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	hhp_state_e state_r;
	hhp_state_e state_nxt;

	// next state: edges ignored while measuring, accepted in idle and done
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			HHP_IDLE: if (trig) state_nxt = HHP_MEAS; // R10
			HHP_MEAS: if (meas_done_i) state_nxt = HHP_DONE;
			HHP_DONE: if (trig) state_nxt = HHP_MEAS; // R10
			default: state_nxt = HHP_IDLE;
		endcase
	end

	wire invalid_nxt = (state_nxt == HHP_MEAS);
	wire start_nxt = (state_r != HHP_MEAS) & (state_nxt == HHP_MEAS); // R10
	wire ready_nxt = (state_nxt == HHP_DONE);
	// completion level per mode
	wire done_lvl = (dmode_r == `HHP_DONE_LOW) ? ~ready_nxt : // R1
		(dmode_r == `HHP_DONE_INVLOW) ? ~invalid_nxt : // R3
		ready_nxt; // R2
	wire busy_lvl = bpol_r ? invalid_nxt : ~invalid_nxt; // R4 R5

	// state and registered outputs
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= HHP_IDLE;
			meas_start_o <= 1'h0;
			done_o <= 1'h0;
			busy_o <= 1'h0;
			cfg_err_o <= 1'h0;
		end
		else
		begin
			state_r <= state_nxt;
			meas_start_o <= start_nxt;
			done_o <= done_lvl;
			busy_o <= busy_lvl;
			cfg_err_o <= perr_r;
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	// busy stands at its invalid level for the whole measurement
	busy_high_a: assert property (@(posedge clock_i) disable iff (rst_i) // R4
		(bpol_r && state_r == HHP_MEAS) |-> busy_o)
		else $error("busy not high while invalid");
	busy_low_a: assert property (@(posedge clock_i) disable iff (rst_i) // R5
		(!bpol_r && state_r == HHP_MEAS) |-> !busy_o)
		else $error("busy not low while invalid");
	// busy turns invalid on the same edge as the start pulse
	start_busy_a: assert property (@(posedge clock_i) disable iff (rst_i) // R4 R5
		meas_start_o |-> (busy_o == bpol_r))
		else $error("busy late at start");
	// completion level once the result is ready
	done_high_a: assert property (@(posedge clock_i) disable iff (rst_i) // R2
		(dmode_r == `HHP_DONE_HIGH && state_r == HHP_DONE) |-> done_o)
		else $error("done not high");
	// the spare mode code behaves as high-when-ready
	spare_high_a: assert property (@(posedge clock_i) disable iff (rst_i) // R2
		(dmode_r == `HHP_DONE_SPARE && state_r == HHP_DONE) |-> done_o)
		else $error("spare mode done not high");
	done_low_a: assert property (@(posedge clock_i) disable iff (rst_i) // R1
		(dmode_r == `HHP_DONE_LOW && state_r == HHP_DONE) |-> !done_o)
		else $error("done not low");
	// invalid-low mode pulls completion low during the measurement
	done_inv_a: assert property (@(posedge clock_i) disable iff (rst_i) // R3
		(dmode_r == `HHP_DONE_INVLOW && state_r == HHP_MEAS) |-> !done_o)
		else $error("done not low while invalid");
	// illegal straps keep the sequencer parked with no start
	bad_path_a: assert property (@(posedge clock_i) disable iff (rst_i) // R6
		perr_r |-> (state_r == HHP_IDLE && !meas_start_o))
		else $error("start with illegal path");
	// each qualifying edge starts a measurement on the following edge
	iso_rise_a: assert property (@(posedge clock_i) disable iff (rst_i) // R8
		(iso_r && esel_r && !perr_r && arm_r[1] && state_r != HHP_MEAS && $rose(sync2_r)) |=> meas_start_o)
		else $error("isolated rising edge missed");
	iso_fall_a: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		(iso_r && !esel_r && !perr_r && arm_r[1] && state_r != HHP_MEAS && $fell(sync2_r)) |=> meas_start_o)
		else $error("isolated falling edge missed");
	logic_rise_a: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		(!iso_r && !esel_r && !perr_r && arm_r[1] && state_r != HHP_MEAS && $rose(sync2_r)) |=> meas_start_o)
		else $error("logic rising edge missed");
	logic_fall_a: assert property (@(posedge clock_i) disable iff (rst_i) // R8
		(!iso_r && esel_r && !perr_r && arm_r[1] && state_r != HHP_MEAS && $fell(sync2_r)) |=> meas_start_o)
		else $error("logic falling edge missed");
	// edges while measuring neither restart nor end the measurement
	busy_hold_a: assert property (@(posedge clock_i) disable iff (rst_i) // R10
		(state_r == HHP_MEAS && !meas_done_i) |=> (state_r == HHP_MEAS && !meas_start_o))
		else $error("edge accepted while measuring");
	one_start_a: assert property (@(posedge clock_i) disable iff (rst_i) // R10
		meas_start_o |-> !$past(meas_start_o))
		else $error("double start");
	// sweep mode leaves busy at its invalid level during the measurement, as in plain mode
	sweep_same_a: assert property (@(posedge clock_i) disable iff (rst_i) // R11
		(unused_sweep && state_r == HHP_MEAS) |-> (busy_o == bpol_r))
		else $error("busy differs in sweep mode");
	// defaults hold until the straps are taken
	reset_def_a: assert property (@(posedge clock_i) disable iff (rst_i) // R9
		!cfg_ld_r |-> (iso_r == `HHP_ISO_RST && esel_r == `HHP_EDGE_RST &&
		bpol_r == `HHP_BUSY_RST && dmode_r == `HHP_DONE_RST))
		else $error("bad defaults");

endmodule : hhp_top

`default_nettype wire

//--- bench/hhp_handler_model.sv
/*
 handler model: drives the trigger pin.
 assumes the bench names the next pin level.
*/
`timescale 1ns/1ps
`default_nettype none
module hhp_handler_model (
	// clock
	input wire logic clock_i,
	// requested pin level
	input wire logic want_i,
	// trigger pin
	output logic pin_o
);
	// pin moves just after an edge, like a real handler
	initial pin_o = 1'b0;
	always @(posedge clock_i)
		pin_o <= #1 want_i;
endmodule : hhp_handler_model
`default_nettype wire

//--- bench/handler_handshake_polarity_tb.sv
/*
 bench: one task per group of strap settings.
 assumes the handler model drives the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module handler_handshake_polarity_tb;
	// straps and stimulus
	logic clk = 0, rst = 1, bp = 1, pl = 0, pa = 1, pb = 1, es = 1, sw = 0, want = 0, md = 0;
	logic [1:0] dm = 2'h1;
	// pin and outputs
	logic pin, go, done, busy, err;
	int n_fail = 0, total_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	hhp_handler_model hhp_handler_model_i (.clock_i(clk), .want_i(want), .pin_o(pin));
	hhp_top hhp_top_i (.clock_i(clk), .rst_i(rst), .done_mode_i(dm), .busy_pol_i(bp),
		.path_logic_i(pl), .path_iso_a_i(pa), .path_iso_b_i(pb), .edge_sel_i(es),
		.sweep_mode_i(sw), .start_in_i(pin), .meas_done_i(md), .meas_start_o(go),
		.done_o(done), .busy_o(busy), .cfg_err_o(err));
	task automatic check(input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %b", $time, seen);
		end
	endtask : check
	task automatic report_and_stop;
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// reset with new straps, pin parked at idle
	task automatic boot(input logic [6:0] c, input logic idle);
		rst = 1;
		{dm, bp, pl, pa, pb, es} = c;
		want = idle;
		repeat (5) @(posedge clk);
		#1 rst = 0;
		repeat (3) @(posedge clk) #1;
	endtask : boot
	// move pin, wait for a start or not
	task automatic fire(input logic lvl, input logic exp);
		want = lvl;
		for (int k = 0; k < 8 && !(k > 0 && go === 1'b1); k++)
			@(posedge clk) #1;
		check(go, exp);
	endtask : fire
	// start and check invalid levels {busy, done}
	task automatic start(input logic lvl, input logic [1:0] inv);
		fire(lvl, 1'b1);
		check(busy, inv[1]);
		check(done, inv[0]);
	endtask : start
	// finish and check ready levels {busy, done}
	task automatic stop(input logic [1:0] rdy);
		md = 1;
		@(posedge clk) #1 md = 0;
		@(posedge clk) #1;
		check(busy, rdy[1]);
		check(done, rdy[0]);
	endtask : stop
	task automatic t_default;
		boot(7'h37, 1'b0);
		check(err, 1'b0);
		start(1'b1, 2'h2);
		fire(1'b0, 1'b0);
		fire(1'b1, 1'b0);
		stop(2'h1);
	endtask : t_default
	task automatic t_low_pols;
		sw = 1;
		boot(7'h06, 1'b1);
		start(1'b0, 2'h1);
		stop(2'h2);
		sw = 0;
	endtask : t_low_pols
	task automatic t_logic;
		boot(7'h58, 1'b0);
		start(1'b1, 2'h2);
		stop(2'h1);
		boot(7'h39, 1'b0);
		fire(1'b1, 1'b0);
		start(1'b0, 2'h2);
		stop(2'h1);
	endtask : t_logic
	task automatic t_bad;
		boot(7'h3F, 1'b0);
		check(err, 1'b1);
		fire(1'b1, 1'b0);
		boot(7'h35, 1'b0);
		check(err, 1'b1);
		fire(1'b1, 1'b0);
	endtask : t_bad
	// spare mode code acts as high-when-ready; stray done pulse ignored; restart from ready
	task automatic t_spare;
		boot(7'h77, 1'h0);
		stop(2'h0);
		start(1'h1, 2'h2);
		stop(2'h1);
		fire(1'h0, 1'h0);
		start(1'h1, 2'h2);
		stop(2'h1);
	endtask : t_spare
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	initial
	begin
		t_default();
		t_low_pols();
		t_logic();
		t_bad();
		t_spare();
		report_and_stop();
	end
endmodule : handler_handshake_polarity_tb
`default_nettype wire
